// >>> design/airc_ctrl.sv
// interrupt and reset control register with optional security extension
// assumes a single-cycle strobe master on CORE_CLK; BIG_ENDIAN_PIN is a strap
`timescale 1ns/100ps
// Function
// - upper half reads key status; writes need write key, else discarded
// - key field is one copy shared by both security states
// - byte-order bit read-only, 1 means big-endian, shared by both states
// - prioritise-secure bit writable from secure, nonsecure reads zero, writes ignored
// - prioritise-secure set lowers nonsecure priorities, clear keeps ranges identical
// - three-bit priority grouping field read-write, selects group/subpriority split
// - debug clear-active bit always reads zero
// - grouping value sets binary point of each priority field
// - fault-routing bit secure-writable, resets to zero (fixed at one without security extension), routes faults nonsecure
// - writing one to reset request bit requests system reset, only with security extension; never without it
module airc_ctrl
   import airc_pkg::*;
#(
   parameter bit SECURITY_EXT = 1'b1
)
(
   input  wire logic                  CORE_CLK,        // core clock, 100 MHz
   input  wire logic                  RST_N,           // async reset, active low
   input  wire logic [AIRC_AW-1:0]    ADDR,            // register address
   input  wire logic [31:0]           WDATA,           // write data
   input  wire logic                  WR,              // write strobe
   input  wire logic                  RD,              // read strobe
   input  wire logic                  NS_ACCESS,       // access is from nonsecure state
   output logic      [31:0]           RDATA,           // read data, cycle after RD
   input  wire logic                  BIG_ENDIAN_PIN,  // byte-order strap pin
   input  wire logic [7:0]            PRIO_IN,         // priority value to split
   input  wire logic                  PRIO_NS,         // that value is nonsecure
   output logic      [7:0]            PRIO_GROUP,      // group priority, registered
   output logic      [7:0]            PRIO_SUB,        // subpriority, registered
   output logic                       PSEC_OUT,        // prioritise secure state
   output logic                       FAULT_ROUTE_NS,  // faults routed nonsecure
   output logic                       RESET_REQ_SEC,   // reset request secure only
   output logic                       RESET_REQ        // system reset request pulse
);
   import airc_pkg::*;

   logic [2:0] pg_sec_reg;
   logic [2:0] pg_ns_reg;
   logic       psec_reg;
   logic       frt_reg;
   logic       rrs_reg;
   logic       rreq_reg;
   logic [1:0] strap_sync_reg;
   logic [1:0] strap_fill_reg;
   logic       endian_reg;
   logic       strap_done_reg;
   logic [31:0] rdata_reg;
   logic [7:0] group_next;
   logic [7:0] sub_next;
   logic [7:0] group_reg;
   logic [7:0] sub_reg;
   logic       hit;
   logic       wr_ok;
   logic       sec_wr;
   logic       ns_view;

   function automatic logic [31:0] read_value(input logic ns);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[31:AIRC_KEY_LSB] = AIRC_KEY_STAT;
      v[AIRC_ENDIAN] = endian_reg;
      if (SECURITY_EXT)
      begin
         v[AIRC_PSEC] = ns ? 1'b0 : psec_reg;
         v[AIRC_FRT]  = frt_reg;
         v[AIRC_RRS]  = ns ? 1'b0 : rrs_reg;
         v[AIRC_PG_LSB +: 3] = ns ? pg_ns_reg : pg_sec_reg;
      end
      else
      begin
         v[AIRC_FRT] = 1'b1;
         v[AIRC_PG_LSB +: 3] = pg_sec_reg;
      end
      v[AIRC_RR]  = 1'b0;
      v[AIRC_DCA] = 1'b0;
      v = v & ~AIRC_RSV_MASK;
      return v;
   endfunction

   assign hit     = (ADDR == AIRC_OFFSET);
   assign ns_view = SECURITY_EXT && NS_ACCESS;
   assign wr_ok   = WR && hit && (WDATA[31:AIRC_KEY_LSB] == AIRC_KEY_WRITE);
   assign sec_wr  = wr_ok && SECURITY_EXT && !NS_ACCESS;

   // strap synchroniser, value caught once after reset release
   // fill marks when the second stage holds the pin, not its reset value
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         strap_sync_reg <= 2'h0;
         strap_fill_reg <= 2'h0;
      end
      else
      begin
         strap_sync_reg <= {strap_sync_reg[0], BIG_ENDIAN_PIN};
         strap_fill_reg <= {strap_fill_reg[0], 1'b1};
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         endian_reg     <= 1'b0;
         strap_done_reg <= 1'b0;
      end
      else if (!strap_done_reg && strap_fill_reg[1])
      begin
         endian_reg     <= strap_sync_reg[1];
         strap_done_reg <= 1'b1;
      end
   end

   // banked priority grouping; nonsecure view writes only its own copy
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pg_sec_reg <= AIRC_PG_RST;
         pg_ns_reg  <= AIRC_PG_RST;
      end
      else if (wr_ok)
      begin
         if (ns_view)
         begin
            pg_ns_reg <= WDATA[AIRC_PG_LSB +: 3];
         end
         else
         begin
            pg_sec_reg <= WDATA[AIRC_PG_LSB +: 3];
         end
      end
   end

   // secure-only control bits
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         psec_reg <= AIRC_PSEC_RST;
         frt_reg  <= AIRC_FRT_RST;
         rrs_reg  <= AIRC_RRS_RST;
      end
      else if (sec_wr)
      begin
         psec_reg <= WDATA[AIRC_PSEC];
         frt_reg  <= WDATA[AIRC_FRT];
         rrs_reg  <= WDATA[AIRC_RRS];
      end
   end

   // reset request pulse; nonsecure blocked when secure-only is set
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rreq_reg <= 1'b0;
      end
      else
      begin
         rreq_reg <= wr_ok && SECURITY_EXT && WDATA[AIRC_RR]
                     && !(NS_ACCESS && rrs_reg);
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rdata_reg <= 32'h0000_0000;
      end
      else if (RD && hit)
      begin
         rdata_reg <= read_value(ns_view);
      end
      else
      begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   airc_prio_split airc_prio_split_inst (
      .prio_in   (PRIO_IN),
      .grouping  ((SECURITY_EXT && PRIO_NS) ? pg_ns_reg : pg_sec_reg),
      .nonsecure (SECURITY_EXT && PRIO_NS),
      .boost     (SECURITY_EXT && psec_reg),
      .group_out (group_next),
      .sub_out   (sub_next)
   );

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         group_reg <= 8'h00;
         sub_reg   <= 8'h00;
      end
      else
      begin
         group_reg <= group_next;
         sub_reg   <= sub_next;
      end
   end

   assign RDATA          = rdata_reg;
   assign PRIO_GROUP     = group_reg;
   assign PRIO_SUB       = sub_reg;
   assign PSEC_OUT       = SECURITY_EXT ? psec_reg : 1'b0;
   assign FAULT_ROUTE_NS = SECURITY_EXT ? frt_reg : 1'b1;
   assign RESET_REQ_SEC  = SECURITY_EXT ? rrs_reg : 1'b0;
   assign RESET_REQ      = rreq_reg;

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   sequence s_read;
      RD && hit;
   endsequence
   sequence s_bad_write;
      WR && hit && (WDATA[31:16] != AIRC_KEY_WRITE);
   endsequence
   sequence s_sec_write;
      WR && hit && (WDATA[31:16] == AIRC_KEY_WRITE) && !NS_ACCESS;
   endsequence
   sequence s_ns_write;
      WR && hit && (WDATA[31:16] == AIRC_KEY_WRITE) && NS_ACCESS;
   endsequence
   sequence s_no_read;
      !(RD && hit);
   endsequence

   chk_key_status_read: assert property (s_read |=> RDATA[31:16] == 16'hFA05)
      else $error("key status not returned on read");
   chk_bad_key_ignored: assert property (s_bad_write |=>
      $stable(pg_sec_reg) && $stable(pg_ns_reg) && $stable(psec_reg) && !RESET_REQ)
      else $error("write with wrong key took effect");
   chk_grouping_write: assert property (s_sec_write |=>
      pg_sec_reg == $past(WDATA[10:8]))
      else $error("priority grouping not written");
   chk_psec_ns_ignored: assert property ((WR && hit && NS_ACCESS) |=> $stable(psec_reg))
      else $error("nonsecure write changed prioritise secure");
   chk_psec_ns_raz: assert property ((s_read and NS_ACCESS) |=> !RDATA[14])
      else $error("prioritise secure visible to nonsecure");
   chk_clear_active_raz: assert property (s_read |=> !RDATA[1] && !RDATA[2])
      else $error("write-only bits read as one");
   chk_reserved_zero: assert property ((RDATA & AIRC_RSV_MASK) == 32'h0000_0000)
      else $error("reserved bit read as one");
   chk_reset_req_pulse: assert property ((s_sec_write ##0 WDATA[2] && SECURITY_EXT
      ##1 !WR) |-> RESET_REQ ##1 !RESET_REQ)
      else $error("reset request not a single pulse");
   chk_endian_read: assert property (s_read |=> RDATA[15] == $past(endian_reg))
      else $error("byte order bit wrong");
   chk_ns_boost: assert property ((SECURITY_EXT && psec_reg && PRIO_NS)
      |=> (PRIO_GROUP[7] || PRIO_SUB[7]))
      else $error("nonsecure priority not lowered");
   chk_frt_no_ext: assert property (!SECURITY_EXT |-> FAULT_ROUTE_NS && !PSEC_OUT)
      else $error("fault routing not fixed without security");

   // read path
   chk_rdata_idle_zero: assert property (s_no_read |=>
      RDATA == 32'h0000_0000)
      else $error("read data not zero outside a read");
   chk_key_shared_ns: assert property ((s_read ##0 NS_ACCESS) |=>
      RDATA[31:16] == AIRC_KEY_STAT)
      else $error("key status differs for nonsecure read");
   chk_endian_held: assert property (strap_done_reg |=>
      $stable(endian_reg))
      else $error("byte order changed after capture");

   // security view
   chk_psec_sec_write: assert property ((s_sec_write ##0 SECURITY_EXT) |=>
      psec_reg == $past(WDATA[14]) && frt_reg == $past(WDATA[13]))
      else $error("secure control bits not written");
   chk_frt_ns_ignored: assert property ((WR && hit && NS_ACCESS) |=>
      $stable(frt_reg) && $stable(rrs_reg))
      else $error("nonsecure write changed secure control bits");
   chk_ns_bank_write: assert property ((s_ns_write ##0 SECURITY_EXT) |=>
      pg_ns_reg == $past(WDATA[10:8]) && $stable(pg_sec_reg))
      else $error("nonsecure grouping bank not written alone");
   chk_ns_reset_blocked: assert property ((s_ns_write ##0 rrs_reg) |=>
      !RESET_REQ)
      else $error("nonsecure reset request not blocked");
   chk_rrs_ns_raz: assert property ((s_read ##0 NS_ACCESS) |=>
      !RDATA[3])
      else $error("secure-only reset bit visible to nonsecure");

   // variant without the extension
   chk_no_ext_reset: assert property (!SECURITY_EXT |->
      !RESET_REQ && !RESET_REQ_SEC)
      else $error("reset request active without security");
   chk_no_ext_read: assert property ((s_read ##0 !SECURITY_EXT) |=>
      RDATA[13] && !RDATA[14] && !RDATA[3] && !RDATA[2])
      else $error("fixed bits wrong without security");

   // priority splitter
   chk_split_plain: assert property (!(SECURITY_EXT && psec_reg && PRIO_NS) |=>
      (PRIO_GROUP | PRIO_SUB) == $past(PRIO_IN))
      else $error("priority changed without boost");
   chk_split_disjoint: assert property ((PRIO_GROUP & PRIO_SUB) == 8'h00)
      else $error("group and subpriority overlap");
endmodule

// >>> design/airc_pkg.sv
// constants for the interrupt and reset control register block
// shared by the register bank and its priority splitter
package airc_pkg;
   localparam int          AIRC_AW        = 8;
   localparam logic [7:0]  AIRC_OFFSET    = 8'h00;
   localparam logic [15:0] AIRC_KEY_STAT  = 16'hFA05;
   localparam logic [15:0] AIRC_KEY_WRITE = 16'h05FA;
   localparam int          AIRC_KEY_LSB   = 16;
   localparam int          AIRC_ENDIAN    = 15;
   localparam int          AIRC_PSEC      = 14;
   localparam int          AIRC_FRT       = 13;
   localparam int          AIRC_PG_LSB    = 8;
   localparam int          AIRC_RRS       = 3;
   localparam int          AIRC_RR        = 2;
   localparam int          AIRC_DCA       = 1;
   localparam logic [31:0] AIRC_RSV_MASK  = 32'h0000_18F1;
   localparam logic [2:0]  AIRC_PG_RST    = 3'h0;
   localparam logic        AIRC_PSEC_RST  = 1'b0;
   localparam logic        AIRC_FRT_RST   = 1'b0;
   localparam logic        AIRC_RRS_RST   = 1'b0;
   localparam int          AIRC_PRIO_W    = 8;
   localparam logic [7:0]  AIRC_PRIO_TOP  = 8'h80;
endpackage

// >>> design/airc_prio_split.sv
// splits one priority value into group and subpriority at the binary point
// assumes a registered consumer; purely combinational
`timescale 1ns/100ps
module airc_prio_split
   import airc_pkg::*;
(
   input  wire logic [7:0] prio_in,      // raw priority value
   input  wire logic [2:0] grouping,     // binary point position
   input  wire logic       nonsecure,    // value belongs to a nonsecure exception
   input  wire logic       boost,        // prioritise secure enabled
   output logic      [7:0] group_out,    // group priority bits, left aligned
   output logic      [7:0] sub_out       // subpriority bits
);
   import airc_pkg::*;
   logic [7:0] eff;
   logic [7:0] sub_mask;

   always_comb
   begin
      // nonsecure values pushed into lower half when boosting
      eff = (nonsecure && boost) ? (AIRC_PRIO_TOP | (prio_in >> 1)) : prio_in;
      sub_mask = ~(8'hFF << ({1'b0, grouping} + 4'h1));
      group_out = eff & ~sub_mask;
      sub_out   = eff & sub_mask;
   end
endmodule

// >>> verif/airc_ctrl_tb.sv
// self-checking bench for the interrupt and reset control register
// drives both security variants from one strobe bus; no partner model
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
   $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
module airc_ctrl_tb;
   import airc_pkg::*;
   logic                 CORE_CLK       = 1'b0;
   logic                 RST_N          = 1'b0;
   logic [AIRC_AW-1:0]   ADDR           = 8'h00;
   logic [31:0]          WDATA          = 32'h0000_0000;
   logic                 WR             = 1'b0;
   logic                 RD             = 1'b0;
   logic                 NS_ACCESS      = 1'b0;
   logic                 BIG_ENDIAN_PIN = 1'b1;
   logic [7:0]           PRIO_IN        = 8'h00;
   logic                 PRIO_NS        = 1'b0;
   logic [31:0]          RDATA;
   logic [31:0]          nx_rdata;
   logic [7:0]           PRIO_GROUP;
   logic [7:0]           PRIO_SUB;
   logic                 PSEC_OUT, FAULT_ROUTE_NS, RESET_REQ_SEC, RESET_REQ;
   logic                 nx_psec, nx_frt, nx_rrs, nx_rr;
   logic [31:0]          d;
   int                   n_fail  = 0;
   int                   checked = 0;

   airc_ctrl #(.SECURITY_EXT(1'b1)) airc_ctrl_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .NS_ACCESS(NS_ACCESS), .RDATA(RDATA),
      .BIG_ENDIAN_PIN(BIG_ENDIAN_PIN), .PRIO_IN(PRIO_IN), .PRIO_NS(PRIO_NS),
      .PRIO_GROUP(PRIO_GROUP), .PRIO_SUB(PRIO_SUB), .PSEC_OUT(PSEC_OUT),
      .FAULT_ROUTE_NS(FAULT_ROUTE_NS), .RESET_REQ_SEC(RESET_REQ_SEC), .RESET_REQ(RESET_REQ));
   // variant without the security extension, sharing the bus
   airc_ctrl #(.SECURITY_EXT(1'b0)) airc_ctrl_nx_inst (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .NS_ACCESS(NS_ACCESS), .RDATA(nx_rdata),
      .BIG_ENDIAN_PIN(BIG_ENDIAN_PIN), .PRIO_IN(PRIO_IN), .PRIO_NS(PRIO_NS),
      .PRIO_GROUP(), .PRIO_SUB(), .PSEC_OUT(nx_psec), .FAULT_ROUTE_NS(nx_frt),
      .RESET_REQ_SEC(nx_rrs), .RESET_REQ(nx_rr));

   initial
   begin
      forever #5 CORE_CLK = ~CORE_CLK;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge CORE_CLK);
      WR    <= 1'b1;
      ADDR  <= a;
      WDATA <= v;
      @(posedge CORE_CLK);
      WR    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge CORE_CLK);
      RD   <= 1'b1;
      ADDR <= a;
      @(posedge CORE_CLK);
      RD   <= 1'b0;
      #1 v = RDATA;
   endtask

   task automatic split(input logic [7:0] p, input logic ns, input logic [7:0] g,
                        input logic [7:0] s);
      @(posedge CORE_CLK);
      PRIO_IN <= p;
      PRIO_NS <= ns;
      @(posedge CORE_CLK);
      #1 `CHK({PRIO_GROUP, PRIO_SUB}, {g, s})
   endtask

   task automatic t_reset_values;
      rd(8'h00, d);
      `CHK(d, 32'hFA05_8000)
      `CHK(nx_rdata, 32'hFA05_A000)
      `CHK({PSEC_OUT, FAULT_ROUTE_NS, RESET_REQ_SEC, RESET_REQ}, 4'h0)
   endtask

   task automatic t_keyless_and_unmapped;
      wr(8'h00, 32'h1234_0500);
      wr(8'h04, 32'h05FA_0500);
      rd(8'h00, d);
      `CHK(d, 32'hFA05_8000)
      rd(8'h04, d);
      `CHK(d, 32'h0000_0000)
   endtask

   task automatic t_full_write;
      wr(8'h00, 32'h05FA_7FFD);
      #1 `CHK({RESET_REQ, nx_rr}, 2'b10)
      @(posedge CORE_CLK);
      #1 `CHK(RESET_REQ, 1'b0)
      `CHK({PSEC_OUT, FAULT_ROUTE_NS, RESET_REQ_SEC}, 3'h7)
      `CHK({nx_psec, nx_frt, nx_rrs}, 3'b010)
      rd(8'h00, d);
      `CHK(d, 32'hFA05_E708)
      `CHK(nx_rdata, 32'hFA05_A700)
   endtask

   task automatic t_nonsecure_bank;
      @(posedge CORE_CLK);
      NS_ACCESS <= 1'b1;
      rd(8'h00, d);
      `CHK(d, 32'hFA05_A000)
      wr(8'h00, 32'h05FA_0204);
      #1 `CHK(RESET_REQ, 1'b0)
      rd(8'h00, d);
      `CHK(d, 32'hFA05_A200)
      @(posedge CORE_CLK);
      NS_ACCESS <= 1'b0;
      rd(8'h00, d);
      `CHK(d, 32'hFA05_E708)
   endtask

   task automatic t_priority_split;
      wr(8'h00, 32'h05FA_2308);
      split(8'hAB, 1'b0, 8'hA0, 8'h0B);
      split(8'hAB, 1'b1, 8'hA8, 8'h03);
      wr(8'h00, 32'h05FA_6308);
      split(8'hAB, 1'b1, 8'hD0, 8'h05);
      split(8'hAB, 1'b0, 8'hA0, 8'h0B);
   endtask

   task automatic t_second_reset;
      @(posedge CORE_CLK);
      RST_N          <= 1'b0;
      BIG_ENDIAN_PIN <= 1'b0;
      repeat (3) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      repeat (4) @(posedge CORE_CLK);
      rd(8'h00, d);
      `CHK(d, 32'hFA05_0000)
   endtask

   task automatic tally_and_finish;
      if (n_fail == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      #20000;
      n_fail++;
      tally_and_finish();
   end

   initial
   begin
      repeat (20) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      repeat (4) @(posedge CORE_CLK);
      t_reset_values();
      t_keyless_and_unmapped();
      t_full_write();
      t_nonsecure_bank();
      t_priority_split();
      t_second_reset();
      tally_and_finish();
   end
endmodule
